// >>> opsq_defines.vh
`ifndef OPSQ_DEFINES_VH
`define OPSQ_DEFINES_VH

// apb register byte offsets
`define OPSQ_CTRL_OFF         12'h000
`define OPSQ_SW6_OFF          12'h004
`define OPSQ_SW3_OFF          12'h008
`define OPSQ_SHB2_OFF         12'h00C
`define OPSQ_SHAUX_OFF        12'h010
`define OPSQ_STAT_OFF         12'h014

// ctrl fields
`define OPSQ_CTRL_CFG_BIT     0
`define OPSQ_CTRL_GRP_BIT     1
`define OPSQ_CTRL_RST         2'h0

// code field positions
`define OPSQ_CODE_W           8
`define OPSQ_SW6_HI_LSB       0
`define OPSQ_SW6_LO_LSB       8
`define OPSQ_SW6_SLP_LSB      16
`define OPSQ_SW3_ACT_LSB      0
`define OPSQ_SW3_SLP_LSB      8
`define OPSQ_SW3_SLPEN_BIT    16

// factory default codes (10 mV steps from 0.41 V for switcher six)
`define OPSQ_SW6_HI_RST       8'h6D
`define OPSQ_SW6_LO_RST       8'h4F
`define OPSQ_SW6_SLP_RST      8'h45
`define OPSQ_SW3_ACT_RST      8'h1C
`define OPSQ_SW3_SLP_RST      8'h18
`define OPSQ_SW3_SLPEN_RST    1'h1
`define OPSQ_AUX1_RST         8'h10

// timing
`define OPSQ_CLK_HZ           50000000
`define OPSQ_TICK_US          1000
`define OPSQ_TICK_CYC         ((`OPSQ_CLK_HZ / 1000000) * `OPSQ_TICK_US)
`define OPSQ_STEP_MS          2
`define OPSQ_STEP_TICKS       (`OPSQ_STEP_MS * 1000 / `OPSQ_TICK_US)
`define OPSQ_POR_MS           50
`define OPSQ_POR_TICKS        (`OPSQ_POR_MS * 1000 / `OPSQ_TICK_US)

// sequencing shape
`define OPSQ_NSTAGE           5
`define OPSQ_NSYNC            11

`endif

// >>> opsq_timebase.v
`timescale 1ns/1ps
`include "opsq_defines.vh"

module opsq_timebase #(
    parameter TICK_CYC = `OPSQ_TICK_CYC
) (
    input  wire                     sys_clk,   // system clock
    input  wire                     rstn,      // async reset, active low
    input  wire [`OPSQ_NSYNC-1:0]   async_in,  // pins and power-good levels
    output wire [`OPSQ_NSYNC-1:0]   sync_out,  // synchronised levels
    output reg                      tick       // one-cycle timebase enable
);

    reg  [`OPSQ_NSYNC-1:0] meta_reg;
    reg  [`OPSQ_NSYNC-1:0] sync_reg;
    reg  [31:0]            div_reg;

    genvar gi;
    generate
        for (gi = 0; gi < `OPSQ_NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    meta_reg[gi] <= 1'b0;
                    sync_reg[gi] <= 1'b0;
                end else begin
                    meta_reg[gi] <= async_in[gi];
                    sync_reg[gi] <= meta_reg[gi];
                end
            end
        end
    endgenerate

    assign sync_out = sync_reg;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 32'h0;
            tick    <= 1'b0;
        end else if (div_reg == TICK_CYC - 1) begin
            div_reg <= 32'h0;
            tick    <= 1'b1;
        end else begin
            div_reg <= div_reg + 32'h1;
            tick    <= 1'b0;
        end
    end

endmodule

// >>> opsq_sequencer.v
`timescale 1ns/1ps
`include "opsq_defines.vh"

module opsq_sequencer #(
    parameter TICK_CYC = `OPSQ_TICK_CYC
) (
    input  wire                      sys_clk,              // 50 MHz clock
    input  wire                      rstn,                 // async reset, active low
    input  wire                      psel,                 // apb select
    input  wire                      penable,              // apb enable
    input  wire                      pwrite,               // apb direction
    input  wire [11:0]               paddr,                // apb byte address
    input  wire [31:0]               pwdata,               // apb write data
    output wire                      pready,               // apb ready
    output reg  [31:0]               prdata,               // apb read data
    output wire                      pslverr,              // apb error, unmapped
    input  wire                      seq_input_one,        // control pin 1
    input  wire                      seq_input_two,        // control pin 2
    input  wire                      seq_input_three,      // control pin 3
    input  wire                      seq_input_four,       // control pin 4
    input  wire                      seq_input_five,       // control pin 5
    input  wire                      seq_input_six,        // control pin 6
    input  wire [`OPSQ_NSTAGE-1:0]   stage_pg,             // rail group power-good
    output reg  [`OPSQ_NSTAGE-1:0]   stage_en,             // rail group enables
    output reg                       load_switch_a_en,     // load switch A enable
    output reg  [7:0]                switcher_six_code,    // switcher six voltage code
    output reg  [7:0]                switcher_three_code,  // switcher three voltage code
    output reg  [7:0]                aux_linear_one_code,  // aux linear one voltage code
    output wire                      status_out_one_o,     // open drain, always 0
    output reg                       status_out_one_oe,    // pulls pin low
    output wire                      status_out_three_o,   // open drain, always 0
    output reg                       status_out_three_oe,  // pulls pin low
    output wire                      status_out_four_o,    // open drain, always 0
    output reg                       status_out_four_oe    // pulls pin low
);

    wire [`OPSQ_NSYNC-1:0]  raw_in;
    wire [`OPSQ_NSYNC-1:0]  syn;
    wire                    tick;
    wire                    in1;
    wire                    in2;
    wire                    in3;
    wire                    in4;
    wire                    in5;
    wire                    in6;
    wire [`OPSQ_NSTAGE-1:0] pg;

    reg  [1:0]              ctrl_reg;
    reg  [23:0]             sw6_reg;
    reg  [16:0]             sw3_reg;
    reg  [7:0]              aux1_reg;
    reg                     in4_d_reg;
    reg                     run_reg;
    reg  [7:0]              por_cnt_reg;
    reg  [`OPSQ_NSTAGE-1:0] run_req;
    reg  [`OPSQ_NSTAGE-1:0] gate_ok;
    reg  [`OPSQ_NSTAGE-1:0] prev_pg;
    reg  [`OPSQ_NSTAGE-1:0] next_pg;
    reg  [7:0]              dly_reg [0:`OPSQ_NSTAGE-1];
    reg                     hit;
    reg  [31:0]             rd_next;

    wire                    cfg_b;
    wire                    grp_en;
    wire                    wr_en;
    wire [31:0]             stat_word;
    wire [`OPSQ_NSTAGE-1:0] req_first;
    wire [`OPSQ_NSTAGE-1:0] req_second;
    wire [`OPSQ_NSTAGE-1:0] gate_first;
    wire [`OPSQ_NSTAGE-1:0] gate_second;

    assign raw_in = {stage_pg, seq_input_six, seq_input_five, seq_input_four,
                     seq_input_three, seq_input_two, seq_input_one};

    // synchronisers and the timebase tick enable
    opsq_timebase #(
        .TICK_CYC (TICK_CYC)
    ) u_tb (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .async_in (raw_in),
        .sync_out (syn),
        .tick     (tick)
    );

    assign in1 = syn[0];
    assign in2 = syn[1];
    assign in3 = syn[2];
    assign in4 = syn[3];
    assign in5 = syn[4];
    assign in6 = syn[5];
    assign pg  = syn[10:6];

    assign cfg_b  = ctrl_reg[`OPSQ_CTRL_CFG_BIT];
    assign grp_en = ctrl_reg[`OPSQ_CTRL_GRP_BIT];

    // apb slave, zero wait states
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign pslverr = psel && penable && !hit;

    // read-only status word, upper bits read zero
    assign stat_word = {11'h0,
                        status_out_four_oe,
                        status_out_three_oe,
                        status_out_one_oe,
                        load_switch_a_en,
                        run_reg,
                        pg,
                        stage_en,
                        syn[5:0]};

    // read mux, unmapped offsets flag pslverr
    always @* begin
        hit     = 1'b1;
        rd_next = 32'h0;
        case (paddr)
            `OPSQ_CTRL_OFF:  rd_next = {30'h0, ctrl_reg};
            `OPSQ_SW6_OFF:   rd_next = {8'h0, sw6_reg};
            `OPSQ_SW3_OFF:   rd_next = {15'h0, sw3_reg};
            `OPSQ_SHB2_OFF:  rd_next = 32'h0;
            `OPSQ_SHAUX_OFF: rd_next = {24'h0, aux1_reg};
            `OPSQ_STAT_OFF:  rd_next = stat_word;
            default:         hit = 1'b0;
        endcase
    end

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= `OPSQ_CTRL_RST;
            sw6_reg  <= {`OPSQ_SW6_SLP_RST, `OPSQ_SW6_LO_RST, `OPSQ_SW6_HI_RST};
            sw3_reg  <= {`OPSQ_SW3_SLPEN_RST, `OPSQ_SW3_SLP_RST, `OPSQ_SW3_ACT_RST};
            aux1_reg <= `OPSQ_AUX1_RST;
        end else begin
            if (wr_en) begin
                case (paddr)
                    `OPSQ_CTRL_OFF:  ctrl_reg <= pwdata[1:0];
                    `OPSQ_SW6_OFF:   sw6_reg  <= pwdata[23:0];
                    `OPSQ_SW3_OFF:   sw3_reg  <= pwdata[16:0];
                    `OPSQ_SHAUX_OFF: aux1_reg <= pwdata[7:0];
                    default:         ctrl_reg <= ctrl_reg;
                endcase
            end
        end
    end

    // read data captured in the setup cycle, stands through access
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_next;
        end
    end

    // second config start: latched on rising input four, dropped when it falls
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            in4_d_reg <= 1'b0;
            run_reg   <= 1'b0;
        end else begin
            in4_d_reg <= in4;
            if (!in4) begin
                run_reg <= 1'b0;
            end else if (!in4_d_reg) begin
                run_reg <= 1'b1;
            end
        end
    end

    // per-stage request (main start) and gate (independent input) terms
    assign req_first   = {{(`OPSQ_NSTAGE-1){in1 && in6}}, in1};
    assign gate_first  = {(grp_en ? in4 : 1'b1), {(`OPSQ_NSTAGE-1){1'b1}}};
    assign req_second  = {`OPSQ_NSTAGE{run_reg && in1}};
    assign gate_second = {1'b1, in5, in3, 2'h3};

    always @* begin
        if (!cfg_b) begin
            run_req = req_first;
            gate_ok = gate_first;
        end else begin
            run_req = req_second;
            gate_ok = gate_second;
        end
        prev_pg = {pg[`OPSQ_NSTAGE-2:0], 1'b1};
        next_pg = {1'b0, pg[`OPSQ_NSTAGE-1:1]};
    end

    // stage k rises a step after its upstream is good, falls in reverse order
    genvar gs;
    generate
        for (gs = 0; gs < `OPSQ_NSTAGE; gs = gs + 1) begin : g_stage
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    stage_en[gs] <= 1'b0;
                    dly_reg[gs]  <= 8'h0;
                end else if (!gate_ok[gs]) begin
                    stage_en[gs] <= 1'b0;
                    dly_reg[gs]  <= 8'h0;
                end else if (run_req[gs] && prev_pg[gs]) begin
                    if (dly_reg[gs] >= `OPSQ_STEP_TICKS) begin
                        stage_en[gs] <= 1'b1;
                    end else if (tick) begin
                        dly_reg[gs] <= dly_reg[gs] + 8'h1;
                    end
                end else begin
                    dly_reg[gs] <= 8'h0;
                    if (!run_req[gs] && !next_pg[gs]) begin
                        stage_en[gs] <= 1'b0;
                    end else if (run_req[gs] && !prev_pg[gs]) begin
                        stage_en[gs] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // host reset release delay counted in ticks
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            por_cnt_reg <= 8'h0;
        end else if (!in1) begin
            por_cnt_reg <= 8'h0;
        end else if (tick && por_cnt_reg < `OPSQ_POR_TICKS) begin
            por_cnt_reg <= por_cnt_reg + 8'h1;
        end
    end

    assign status_out_one_o   = 1'b0;
    assign status_out_three_o = 1'b0;
    assign status_out_four_o  = 1'b0;

    // load switch A follows input five in the first config, input two in the second
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            load_switch_a_en <= 1'b0;
        end else if (!cfg_b) begin
            load_switch_a_en <= in5;
        end else begin
            load_switch_a_en <= in2;
        end
    end

    // voltage codes picked from the software-writable code registers
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            switcher_six_code   <= `OPSQ_SW6_LO_RST;
            switcher_three_code <= `OPSQ_SW3_ACT_RST;
            aux_linear_one_code <= `OPSQ_AUX1_RST;
        end else begin
            aux_linear_one_code <= aux1_reg;
            if (!cfg_b) begin
                if (in3) begin
                    switcher_six_code <= sw6_reg[`OPSQ_SW6_SLP_LSB +: 8];
                end else if (in2) begin
                    switcher_six_code <= sw6_reg[`OPSQ_SW6_HI_LSB +: 8];
                end else begin
                    switcher_six_code <= sw6_reg[`OPSQ_SW6_LO_LSB +: 8];
                end
                switcher_three_code <= sw3_reg[`OPSQ_SW3_ACT_LSB +: 8];
            end else begin
                switcher_six_code <= sw6_reg[`OPSQ_SW6_LO_LSB +: 8];
                if (in6 && sw3_reg[`OPSQ_SW3_SLPEN_BIT]) begin
                    switcher_three_code <= sw3_reg[`OPSQ_SW3_SLP_LSB +: 8];
                end else begin
                    switcher_three_code <= sw3_reg[`OPSQ_SW3_ACT_LSB +: 8];
                end
            end
        end
    end

    // open-drain status pulls, high while the pin is held low
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_out_one_oe   <= 1'b1;
            status_out_three_oe <= 1'b1;
            status_out_four_oe  <= 1'b1;
        end else if (!cfg_b) begin
            status_out_one_oe   <= !pg[0];
            status_out_three_oe <= !pg[1];
            status_out_four_oe  <= !pg[4];
        end else begin
            status_out_one_oe   <= !(pg[2] && in3);
            status_out_four_oe  <= !(pg[3] && in5);
            status_out_three_oe <= !in1 || (por_cnt_reg < `OPSQ_POR_TICKS);
        end
    end

endmodule

// >>> opsq_sequencer_sva.sv
`timescale 1ns/1ps
module opsq_sequencer_sva #(
    parameter TICK_CYC = 10
) (
    input wire        sys_clk,            // clock
    input wire        rstn,               // reset
    input wire        psel,               // apb
    input wire        penable,            // apb
    input wire        pwrite,             // apb
    input wire [11:0] paddr,              // apb
    input wire [31:0] pwdata,             // apb
    input wire        pready,             // apb
    input wire [31:0] prdata,             // apb
    input wire        pslverr,            // apb
    input wire        seq_input_one,      // pin
    input wire        seq_input_three,    // pin
    input wire        seq_input_five,     // pin
    input wire [4:0]  stage_en,           // rails
    input wire        load_switch_a_en,   // switch
    input wire [7:0]  switcher_six_code,  // code
    input wire        status_out_three_oe // host reset
);
    localparam int POR_MIN = 49 * TICK_CYC;
    wire        wr = psel && penable && pwrite;
    reg         cfg_reg;
    reg  [23:0] sw6_reg;
    reg  [15:0] hi_cnt_reg;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_reg <= 1'b0;
            sw6_reg <= 24'h454F6D;
            hi_cnt_reg <= 16'h0000;
        end else begin
            if (wr && paddr == 12'h000) cfg_reg <= pwdata[0];
            if (wr && paddr == 12'h004) sw6_reg <= pwdata[23:0];
            if (!seq_input_one) hi_cnt_reg <= 16'h0000;
            else if (hi_cnt_reg != 16'hFFFF) hi_cnt_reg <= hi_cnt_reg + 16'h0001;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    unmapped_err_a: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
        else $error("no error on unmapped address");
    unused_set_a: assert property (psel && penable && !pwrite && paddr == 12'h00C
        |-> prdata == 32'h0 && !pslverr) else $error("unused set not read as zero");
    load_first_a: assert property ((!cfg_reg && $stable(seq_input_five))[*5]
        |-> load_switch_a_en == seq_input_five) else $error("switch A ignores input five");
    por_low_a: assert property ((cfg_reg && !seq_input_one)[*5] |-> status_out_three_oe)
        else $error("host reset not held low");
    por_delay_a: assert property (cfg_reg && $fell(status_out_three_oe)
        |-> hi_cnt_reg >= POR_MIN) else $error("host reset released early");
    gate_three_a: assert property ((cfg_reg && !seq_input_three)[*5] |-> !stage_en[2])
        else $error("gated group still on");
    stage_order_a: assert property ((stage_en[4:1] & ~$past(stage_en[4:1])
        & ~stage_en[3:0]) == 4'h0) else $error("stage on before upstream");
    sw6_sleep_a: assert property ((!cfg_reg && seq_input_three && $stable(sw6_reg))[*5]
        |-> switcher_six_code == sw6_reg[23:16]) else $error("sleep code not chosen");
endmodule

bind opsq_sequencer opsq_sequencer_sva #(.TICK_CYC(TICK_CYC)) opsq_sequencer_sva_i (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .seq_input_one(seq_input_one), .seq_input_three(seq_input_three),
    .seq_input_five(seq_input_five), .stage_en(stage_en),
    .load_switch_a_en(load_switch_a_en), .switcher_six_code(switcher_six_code),
    .status_out_three_oe(status_out_three_oe));

// >>> opsq_board_model.sv
`timescale 1ns/1ps
module opsq_board_model #(
    parameter PG_DLY = 4
) (
    input  wire       sys_clk,              // clock
    input  wire [4:0] stage_en,             // rail enables
    input  wire [4:0] pg_hold,              // forced rail fault
    input  wire       one_oe,               // status one pulldown
    input  wire       three_oe,             // status three pulldown
    input  wire       four_oe,              // status four pulldown
    output reg  [4:0] stage_pg,             // rail power-good
    output wire       status_one_pin,       // pulled-up level
    output wire       host_poweron_reset_n, // host reset level
    output wire       status_four_pin       // pulled-up level
);
    reg [3:0] cnt_reg [0:4];
    integer   k;
    initial stage_pg = 5'h00;
    // rail good some cycles after enable, lost at once on disable
    always @(posedge sys_clk) begin
        for (k = 0; k < 5; k = k + 1) begin
            if (!stage_en[k] || pg_hold[k]) cnt_reg[k] <= 4'h0;
            else if (cnt_reg[k] != PG_DLY) cnt_reg[k] <= cnt_reg[k] + 4'h1;
            stage_pg[k] <= stage_en[k] && !pg_hold[k] && cnt_reg[k] == PG_DLY;
        end
    end
    assign status_one_pin = one_oe ? 1'b0 : 1'b1;
    assign host_poweron_reset_n = three_oe ? 1'b0 : 1'b1;
    assign status_four_pin = four_oe ? 1'b0 : 1'b1;
endmodule

// >>> otp_power_sequencer_bench.sv
`timescale 1ns/1ps
module otp_power_sequencer_bench;
    localparam TICK = 10;
    reg         sys_clk = 1'b0;
    reg         rstn    = 1'b0;
    reg         psel    = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite  = 1'b0;
    reg  [11:0] paddr   = 12'h000;
    reg  [31:0] pwdata  = 32'h0;
    reg  [5:0]  pin     = 6'h00;
    reg         tie6    = 1'b0;
    reg  [4:0]  pg_hold = 5'h00;
    wire        pready, pslverr, one_pin, por_n, four_pin, load_a, oe1, oe3, oe4;
    wire [31:0] prdata;
    wire [4:0]  stage_pg, stage_en;
    wire [7:0]  sw6, sw3, aux1;
    reg  [31:0] r;
    reg         e;
    integer     failures = 0;
    integer     checks = 0;
    integer     i, n;
    reg  [23:0] rows [0:6];
    reg  [43:0] regs [0:5];
    always #10 sys_clk = ~sys_clk;
    opsq_sequencer #(.TICK_CYC(TICK)) opsq_sequencer_i (
        .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .seq_input_one(pin[0]), .seq_input_two(pin[1]), .seq_input_three(pin[2]),
        .seq_input_four(pin[3]), .seq_input_five(pin[4]),
        .seq_input_six(tie6 ? one_pin : pin[5]),
        .stage_pg(stage_pg), .stage_en(stage_en), .load_switch_a_en(load_a),
        .switcher_six_code(sw6), .switcher_three_code(sw3), .aux_linear_one_code(aux1),
        .status_out_one_o(), .status_out_one_oe(oe1), .status_out_three_o(),
        .status_out_three_oe(oe3), .status_out_four_o(), .status_out_four_oe(oe4));
    opsq_board_model opsq_board_model_i (
        .sys_clk(sys_clk), .stage_en(stage_en), .pg_hold(pg_hold), .one_oe(oe1),
        .three_oe(oe3), .four_oe(oe4), .stage_pg(stage_pg), .status_one_pin(one_pin),
        .host_poweron_reset_n(por_n), .status_four_pin(four_pin));
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("ERROR %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1) begin
                @(posedge sys_clk);
            end
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rd(input [11:0] a, input [31:0] exp, input ee);
        begin
            apb(1'b0, a, 32'h0);
            check(r, exp);
            check(e, ee);
        end
    endtask
    task cyc(input integer c);
        repeat (c) @(posedge sys_clk);
    endtask
    task wait_en(input [4:0] m, input [4:0] v, input integer lim);
        begin
            n = 0;
            @(negedge sys_clk);
            while ((stage_en & m) !== v && n < lim) begin
                n = n + 1;
                @(negedge sys_clk);
            end
            check(stage_en & m, v);
            @(posedge sys_clk);
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d failures %0d", checks, failures);
            if (failures == 0 && checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    initial begin
        #400000;
        failures = failures + 1;
        give_verdict;
    end
    initial begin
        // cfg, pins, switch A, selected code
        rows = '{24'h0_10_1_4F, 24'h0_02_0_6D, 24'h0_06_0_45, 24'h0_14_1_45,
                 24'h1_02_1_1C, 24'h1_20_0_18, 24'h1_22_1_18};
        regs = '{44'h000_00000000, 44'h004_00454F6D, 44'h008_0001181C,
                 44'h00C_00000000, 44'h010_00000010, 44'h014_001C0000};
        cyc(3);
        check({stage_en, load_a, oe1, oe3, oe4}, 9'h007);
        check({sw6, sw3, aux1}, 24'h4F1C10);
        rstn <= 1'b1;
        for (i = 0; i < 6; i = i + 1) begin
            rd(regs[i][43:32], regs[i][31:0], 1'b0);
        end
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        check(e, 1'b1);
        apb(1'b1, 12'h00C, 32'h000000AB);
        rd(12'h00C, 32'h0, 1'b0);
        rd(12'h020, 32'h0, 1'b1);
        for (i = 0; i < 7; i = i + 1) begin
            apb(1'b1, 12'h000, {31'h0, rows[i][20]});
            pin <= rows[i][17:12];
            cyc(6);
            check(load_a, rows[i][8]);
            check(rows[i][20] ? sw3 : sw6, rows[i][7:0]);
        end
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h00335566);
        apb(1'b1, 12'h010, 32'h00000022);
        pin <= 6'h04;
        cyc(6);
        check({sw6, aux1}, 16'h3322);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b1, 12'h008, 32'h00002A1C);
        pin <= 6'h20;
        cyc(6);
        check(sw3, 8'h1C);
        apb(1'b1, 12'h000, 32'h2);
        tie6 <= 1'b1;
        pin <= 6'h09;
        wait_en(5'h1F, 5'h1F, 400);
        pin <= 6'h01;
        wait_en(5'h10, 5'h00, 20);
        pin <= 6'h00;
        wait_en(5'h1F, 5'h00, 600);
        tie6 <= 1'b0;
        apb(1'b1, 12'h000, 32'h1);
        pg_hold <= 5'h01;
        pin <= 6'h15;
        cyc(100);
        check(stage_en, 5'h00);
        pin <= 6'h1D;
        cyc(100);
        check(stage_en[4:1], 4'h0);
        pg_hold <= 5'h00;
        wait_en(5'h1F, 5'h1F, 400);
        check({one_pin, four_pin}, 2'b11);
        pin <= 6'h19;
        cyc(6);
        check({stage_en[2], one_pin}, 2'b00);
        pin <= 6'h18;
        cyc(5);
        check({oe3, por_n}, 2'b10);
        pin <= 6'h19;
        cyc(48 * TICK);
        check(por_n, 1'b0);
        n = 0;
        while (por_n !== 1'b1 && n < 6 * TICK) begin
            n = n + 1;
            @(negedge sys_clk);
        end
        check(por_n, 1'b1);
        @(posedge sys_clk);
        rstn <= 1'b0;
        cyc(2);
        check({stage_en, load_a, oe3}, 7'h01);
        give_verdict;
    end
endmodule
